//--- logic/sdlc_level_ctrl.v
/*
  switch dimming level control: classifies supply-off intervals, steps a
  strap-selected level sequence and gates output on thermal shutdown.
  assumes the core stays clocked from a hold-up capacitor during short supply
  loss, supply-present and strap pins asynchronous, temperature a sampled code.
  the nominal setpoint is a slow level from the sense stage; the setpoint output
  follows it one clock later. the supply pin is low while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_regs.vh"

// Operation
// R1: power-up selects full level first
// R2: dimming switch advances level, wraps to full
// R3: off over two seconds restores initial state
// R4: off over 2s normal, under 2s dimming
// R5: both straps floating keeps full level
// R6: three-level sequences 100/50/20, 100/60/30
// R7: both grounded alternates full and 30%
// R8: normal switch resets to full level
// R9: off-time counter keeps running while off; here it freezes once the two-second bound is passed
// R10: trip above 150, resume below 130
// R11: setpoint equals level ratio times nominal
// R12: count off-time from loss to return
module sdlc_level_ctrl #(
  parameter TICK_CYCLES = `SDLC_TICK_CYCLES, // clocks per slow tick
  parameter OFF_TICKS   = `SDLC_OFF_TICKS,   // ticks in two seconds
  parameter NOM_W       = 16                 // nominal setpoint width
) (
  input  wire             CLOCK_I,           // 250 MHz clock
  input  wire             RST_I,             // power-up reset
  input  wire             SUPPLY_OK_I,       // supply present, asynchronous
  input  wire             MODE_STRAP_A_I,    // high = floating
  input  wire             MODE_STRAP_B_I,    // high = floating
  input  wire [7:0]       DIE_TEMP_I,        // die temperature, degrees C
  input  wire [NOM_W-1:0] NOMINAL_SET_I,     // initial current setpoint
  output reg  [NOM_W-1:0] DIM_SETPOINT_O,    // dimmed average current setpoint
  output reg  [7:0]       LEVEL_PCT_O,       // selected ratio in percent
  output reg              OUTPUT_ENABLE_O,   // power switch output allowed
  output reg              DIMMING_SWITCH_EVENT_O // pulse per dimming switch, none in mode none
);
  wire       supply_ok;                      // filtered supply present
  wire       strap_a_float;                  // filtered strap a
  wire       strap_b_float;                  // filtered strap b
  reg        supply_ok_d;                    // previous supply state
  reg [31:0] tick_cnt;                       // slow time base divider
  reg        tick;                           // one-cycle slow enable
  reg [31:0] off_cnt;                        // off-time in ticks
  reg        off_long;                       // off beyond two seconds
  reg [1:0]  step;                           // position in sequence
  reg [1:0]  next_step;                      // next position
  reg [1:0]  mode;                           // {a grounded, b grounded}
  reg [7:0]  pct;                            // ratio of current step
  reg        tripped;                        // thermal shutdown latched
  reg [NOM_W+7:0] product;                   // nominal times ratio
  reg [NOM_W+7:0] quotient;                  // product over full ratio

  genvar gi;
  // one synchroniser per asynchronous pin; all reset low, which for the
  // supply is its idle level after power-up, so no false return edge appears,
  // and for the straps reads as grounded until the pins are filtered
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      wire raw;
      wire lvl;
      assign raw = (gi == 0) ? SUPPLY_OK_I : (gi == 1) ? MODE_STRAP_A_I : MODE_STRAP_B_I;
      sdlc_sync3 #(.RESET_VAL(1'b0)) u_sync (
        .clk_i   (CLOCK_I),
        .rst_i   (RST_I),
        .async_i (raw),
        .level_o (lvl)
      );
    end
  endgenerate
  assign supply_ok     = g_sync[0].lvl;
  assign strap_a_float = g_sync[1].lvl;
  assign strap_b_float = g_sync[2].lvl;

  wire supply_loss   = supply_ok_d & ~supply_ok;   // falling edge
  wire supply_return = ~supply_ok_d & supply_ok;   // rising edge

  // slow time base: one-cycle tick every TICK_CYCLES clocks, so the
  // off-time counter stays narrow and its two-second bound is a tick count;
  // the tick runs free, so an off time is measured to within one tick
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // off-time measurement between loss and return
  // off_long stays set after return until the next loss, for the step logic
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      supply_ok_d <= 1'b0;
      off_cnt     <= 32'h0000_0000;
      // power-up counts as a long off, so the first supply return is a
      // normal switch and the lamp starts at full
      off_long    <= 1'b1;                    // [R1]
    end else begin
      supply_ok_d <= supply_ok;
      if (supply_loss) begin
        // a new loss restarts the count and clears the old verdict
        off_cnt  <= 32'h0000_0000;            // [R12]
        off_long <= 1'b0;
      end else if (~supply_ok & tick & ~off_long) begin
        // count only while off, and freeze once the bound is passed
        off_cnt <= off_cnt + 32'h0000_0001;   // [R9] [R12]
        if (off_cnt + 32'h0000_0001 > OFF_TICKS) begin
          off_long <= 1'b1;                   // [R4]
        end
      end
    end
  end

  // strap decode: grounded pin sets its mode bit
  // both high means floating, which selects no dimming
  always @* begin
    mode = {~strap_a_float, ~strap_b_float};
  end

  // next step on a dimming switch
  // three-level modes count 0..2, the two-level mode toggles 0 and 1
  always @* begin
    next_step = step;
    case (mode)
      `SDLC_MODE_1, `SDLC_MODE_2: begin
        next_step = (step == 2'h2) ? 2'h0 : step + 2'h1;     // [R2] [R6]
      end
      `SDLC_MODE_3: begin
        next_step = (step == 2'h1) ? 2'h0 : 2'h1;            // [R7]
      end
      default: begin
        next_step = 2'h0;                                    // [R5]
      end
    endcase
  end

  // level selection state
  // mode none wins over every switch, a long off over a pending return
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      step                   <= 2'h0;                        // [R1]
      DIMMING_SWITCH_EVENT_O <= 1'b0;
    end else begin
      DIMMING_SWITCH_EVENT_O <= 1'b0;
      if (mode == `SDLC_MODE_NONE) begin
        step <= 2'h0;                                        // [R5]
      end else if (~supply_ok & off_long) begin
        step <= 2'h0;                                        // [R3] [R8]
      end else if (supply_return & off_long) begin
        // return after a long off is a normal switch: full, no pulse
        step <= 2'h0;                                        // [R3] [R8]
      end else if (supply_return) begin
        // return after a short off is a dimming switch
        step                   <= next_step;                 // [R4] [R2]
        DIMMING_SWITCH_EVENT_O <= 1'b1;
      end
    end
  end

  // ratio of current step per mode
  // a step code that a mode does not use maps to full
  always @* begin
    pct = `SDLC_PCT_FULL;
    case (mode)
      `SDLC_MODE_1: begin
        pct = (step == 2'h1) ? `SDLC_PCT_50 : (step == 2'h2) ? `SDLC_PCT_20 : `SDLC_PCT_FULL; // [R6]
      end
      `SDLC_MODE_2: begin
        pct = (step == 2'h1) ? `SDLC_PCT_60 : (step == 2'h2) ? `SDLC_PCT_30 : `SDLC_PCT_FULL; // [R6]
      end
      `SDLC_MODE_3: begin
        pct = (step == 2'h1) ? `SDLC_PCT_30 : `SDLC_PCT_FULL; // [R7]
      end
      default: begin
        pct = `SDLC_PCT_FULL;                                 // [R5]
      end
    endcase
  end

  // thermal shutdown with hysteresis
  // the band between the two thresholds keeps the last state, so the lamp
  // does not chatter at the trip point
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      tripped <= 1'b0;
    end else if (DIE_TEMP_I > `SDLC_TRIP_TEMP) begin
      tripped <= 1'b1;                                        // [R10]
    end else if (DIE_TEMP_I < `SDLC_TRIP_TEMP - `SDLC_TRIP_HYST) begin
      tripped <= 1'b0;                                        // [R10]
    end
  end

  // setpoint scaling: nominal times percent, then divided by the full
  // ratio; the quotient never exceeds the nominal, so its low bits are exact
  always @* begin
    product  = NOMINAL_SET_I * pct;
    quotient = product / `SDLC_PCT_FULL;
  end

  // registered outputs
  // output enable needs supply present and no thermal trip
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      DIM_SETPOINT_O  <= {NOM_W{1'b0}};
      LEVEL_PCT_O     <= `SDLC_PCT_FULL;
      OUTPUT_ENABLE_O <= 1'b0;
    end else begin
      DIM_SETPOINT_O  <= quotient[NOM_W-1:0];                 // [R11]
      LEVEL_PCT_O     <= pct;
      OUTPUT_ENABLE_O <= supply_ok & ~tripped;                // [R10]
    end
  end
endmodule
`default_nettype wire

//--- logic/sdlc_sync3.v
/*
  three-flop synchroniser with agreement filter for asynchronous pins.
  assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sdlc_sync3 #(
  parameter RESET_VAL = 1'b0          // level assumed during reset
) (
  input  wire clk_i,                  // block clock
  input  wire rst_i,                  // asynchronous reset
  input  wire async_i,                // raw pin
  output reg  level_o                 // filtered level
);
  reg s1;                             // metastability flop, read by s2 only
  reg s2;                             // second stage
  reg s3;                             // third stage

  // level changes once stages two and three agree
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1      <= RESET_VAL;
      s2      <= RESET_VAL;
      s3      <= RESET_VAL;
      level_o <= RESET_VAL;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule
`default_nettype wire

//--- pkg/sdlc_regs.vh
/*
  constants of the switch dimming level control: level ratios, strap modes,
  thermal thresholds and off-time timing.
  assumes inclusion by bare name from design files.
*/
`ifndef SDLC_REGS_VH
`define SDLC_REGS_VH

// level ratios in percent of the initial current
`define SDLC_PCT_FULL      8'h64
`define SDLC_PCT_50        8'h32
`define SDLC_PCT_20        8'h14
`define SDLC_PCT_60        8'h3c
`define SDLC_PCT_30        8'h1e

// strap modes {a_grounded, b_grounded}
`define SDLC_MODE_NONE     2'h0
`define SDLC_MODE_1        2'h1
`define SDLC_MODE_2        2'h2
`define SDLC_MODE_3        2'h3

// thermal thresholds in degrees C
`define SDLC_TRIP_TEMP     8'h96
`define SDLC_TRIP_HYST     8'h14

// off-time boundary in ms, slow tick period in ms, clock in MHz
`define SDLC_OFF_LIMIT_MS  2000
`define SDLC_TICK_MS       1
`define SDLC_CLK_MHZ       250
`define SDLC_TICK_CYCLES   (`SDLC_TICK_MS * 1000 * `SDLC_CLK_MHZ)
`define SDLC_OFF_TICKS     (`SDLC_OFF_LIMIT_MS / `SDLC_TICK_MS)

`endif

//--- test/sdlc_level_ctrl_bench.sv
/* bench of the level control with a wall switch model.
   assumes ten clocks a tick and five ticks for the long off. */
`timescale 1ns/1ps
`default_nettype none
module sdlc_level_ctrl_bench;
  logic        clock = 1'b0;   // 250 MHz
  logic        rst   = 1'b1;   // power-up reset
  logic [7:0]  temp  = 8'h19;  // die temperature
  logic [15:0] nominal = 16'h03e8; // nominal setpoint, 1000
  logic        supply;         // supply present
  logic        strap_a;        // strap a
  logic        strap_b;        // strap b
  logic [15:0] setpoint;       // dimmed setpoint
  logic [7:0]  pct;            // level ratio
  logic        enable;         // output allowed
  logic        ev;             // switch pulse
  int          n_errors = 0;   // mismatches
  int          num_checks = 0; // comparisons
  int          n_events = 0;   // switch pulses seen
  initial begin
    forever #2 clock = ~clock;
  end
  sdlc_wall_switch i_sdlc_wall_switch (.clk_i(clock), .supply_o(supply), .strap_a_o(strap_a),
    .strap_b_o(strap_b));
  sdlc_level_ctrl #(.TICK_CYCLES(10), .OFF_TICKS(5)) i_sdlc_level_ctrl (.CLOCK_I(clock), .RST_I(rst),
    .SUPPLY_OK_I(supply), .MODE_STRAP_A_I(strap_a), .MODE_STRAP_B_I(strap_b), .DIE_TEMP_I(temp),
    .NOMINAL_SET_I(nominal), .DIM_SETPOINT_O(setpoint), .LEVEL_PCT_O(pct), .OUTPUT_ENABLE_O(enable),
    .DIMMING_SWITCH_EVENT_O(ev));
  // count switch pulses; each stands one cycle
  always @(posedge clock) begin
    if (ev === 1'b1) begin
      n_events++;
    end
  end
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ratio and setpoint of a level against the bench nominal
  task automatic level(input logic [7:0] p);
    check("pct", {8'h00, pct}, {8'h00, p});
    check("setpoint", setpoint, 16'((32'(nominal) * 32'(p)) / 32'h0000_0064));
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // each mode: long off to full, then three short offs; mode none last
  task automatic t_sequence;
    logic [7:0] seq [4][3] = '{'{8'h64, 8'h64, 8'h64}, '{8'h32, 8'h14, 8'h64},
                               '{8'h3c, 8'h1e, 8'h64}, '{8'h1e, 8'h64, 8'h1e}};
    int ev_base;
    for (int m = 1; m < 5; m++) begin
      i_sdlc_wall_switch.straps(!m[1], !m[0]);
      ev_base = n_events;
      i_sdlc_wall_switch.cut(120);
      level(8'h64);
      check("long events", 16'(n_events - ev_base), 16'h0000);
      for (int s = 0; s < 3; s++) begin
        ev_base = n_events;
        i_sdlc_wall_switch.cut(20);
        level(seq[m % 4][s]);
        check("short events", 16'(n_events - ev_base), (m == 4) ? 16'h0000 : 16'h0001);
      end
    end
  endtask
  // dim once in the first mode, then the setpoint follows a new nominal
  task automatic t_nominal;
    int ev_base;
    i_sdlc_wall_switch.straps(1'b1, 1'b0);
    ev_base = n_events;
    i_sdlc_wall_switch.cut(20);
    level(8'h32);
    check("dim events", 16'(n_events - ev_base), 16'h0001);
    @(posedge clock) nominal <= 16'h0bb8;
    repeat (4) @(posedge clock);
    level(8'h32);
  endtask
  // trip, hold inside the hysteresis band, then resume
  task automatic t_thermal;
    @(posedge clock) temp <= 8'ha0;
    repeat (4) @(posedge clock);
    check("trip", {15'h0, enable}, 16'h0000);
    temp <= 8'h8c;
    repeat (12) @(posedge clock);
    check("hold", {15'h0, enable}, 16'h0000);
    temp <= 8'h78;
    repeat (4) @(posedge clock);
    check("resume", {15'h0, enable}, 16'h0001);
  endtask
  // power up at a dimming mode must still start at full
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    i_sdlc_wall_switch.cut(1);
    level(8'h64);
    check("power-up events", 16'(n_events), 16'h0000);
    t_sequence();
    t_nominal();
    t_thermal();
    give_verdict();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    give_verdict();
  end
endmodule
bind sdlc_level_ctrl sdlc_level_ctrl_sva #(.NOM_W(NOM_W)) i_sdlc_level_ctrl_sva (.CLOCK_I(CLOCK_I),
  .RST_I(RST_I), .SUPPLY_OK_I(SUPPLY_OK_I), .MODE_STRAP_A_I(MODE_STRAP_A_I), .MODE_STRAP_B_I(MODE_STRAP_B_I),
  .DIE_TEMP_I(DIE_TEMP_I), .NOMINAL_SET_I(NOMINAL_SET_I), .DIM_SETPOINT_O(DIM_SETPOINT_O),
  .LEVEL_PCT_O(LEVEL_PCT_O), .OUTPUT_ENABLE_O(OUTPUT_ENABLE_O), .DIMMING_SWITCH_EVENT_O(DIMMING_SWITCH_EVENT_O));
`default_nettype wire

//--- test/sdlc_level_ctrl_sva.sv
/* port assertions of the level control.
   assumes a bind onto the level control top. */
`timescale 1ns/1ps
`default_nettype none
module sdlc_level_ctrl_sva #(
  parameter NOM_W = 16                                // setpoint width
) (
  input wire logic             CLOCK_I,               // block clock
  input wire logic             RST_I,                 // power-up reset
  input wire logic             SUPPLY_OK_I,           // supply present
  input wire logic             MODE_STRAP_A_I,        // high = floating
  input wire logic             MODE_STRAP_B_I,        // high = floating
  input wire logic [7:0]       DIE_TEMP_I,            // die temperature
  input wire logic [NOM_W-1:0] NOMINAL_SET_I,         // nominal setpoint
  input wire logic [NOM_W-1:0] DIM_SETPOINT_O,        // dimmed setpoint
  input wire logic [7:0]       LEVEL_PCT_O,           // level ratio
  input wire logic             OUTPUT_ENABLE_O,       // output allowed
  input wire logic             DIMMING_SWITCH_EVENT_O // switch pulse
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  a_pct_legal: assert property (LEVEL_PCT_O inside {8'h64, 8'h32, 8'h14, 8'h3c, 8'h1e})
    else $error("level ratio off the table");
  a_setpoint_scale: assert property ($stable(NOMINAL_SET_I) [*3] |->
    DIM_SETPOINT_O == NOMINAL_SET_I * LEVEL_PCT_O / 100) else $error("setpoint not scaled");
  a_none_full: assert property ((MODE_STRAP_A_I && MODE_STRAP_B_I) [*8] |-> LEVEL_PCT_O == 8'h64)
    else $error("dimmed with both straps floating");
  a_trip_off: assert property (DIE_TEMP_I > 8'h96 [*2] |=> !OUTPUT_ENABLE_O)
    else $error("output on above trip");
  a_trip_hold: assert property (DIE_TEMP_I > 8'h96 ##1 DIE_TEMP_I >= 8'h82 [*8] |=> !OUTPUT_ENABLE_O)
    else $error("resumed inside hysteresis");
  a_resume_on: assert property ((SUPPLY_OK_I && DIE_TEMP_I < 8'h82) [*8] |=> OUTPUT_ENABLE_O)
    else $error("output not resumed");
  a_event_single: assert property (DIMMING_SWITCH_EVENT_O |=> !DIMMING_SWITCH_EVENT_O [*8])
    else $error("switch pulse repeated");
  a_step_cause: assert property ($changed(LEVEL_PCT_O) && LEVEL_PCT_O != 8'h64 |->
    DIMMING_SWITCH_EVENT_O || $past(DIMMING_SWITCH_EVENT_O) || $past(DIMMING_SWITCH_EVENT_O, 2))
    else $error("dim step without switch");
  a_mode3_step: assert property (DIMMING_SWITCH_EVENT_O && !MODE_STRAP_A_I && !MODE_STRAP_B_I
    && LEVEL_PCT_O == 8'h64 |-> ##[0:3] LEVEL_PCT_O == 8'h1e) else $error("two-level step wrong");
endmodule
`default_nettype wire

//--- test/sdlc_wall_switch.sv
/* wall switch on the supply line and the two strap pins.
   assumes the bench calls its tasks from one process. */
`timescale 1ns/1ps
`default_nettype none
module sdlc_wall_switch (
  input  wire logic clk_i,     // block clock
  output var  logic supply_o,  // supply present
  output var  logic strap_a_o, // high = floating
  output var  logic strap_b_o  // high = floating
);
  // supply off until the bench powers up; straps at the first mode
  initial begin
    supply_o  = 1'b0;
    strap_a_o = 1'b1;
    strap_b_o = 1'b0;
  end
  // off for a count of cycles, then on and settle past the filter
  task automatic cut(input int off);
    @(posedge clk_i) supply_o <= 1'b0;
    repeat (off) @(posedge clk_i);
    supply_o <= 1'b1;
    repeat (16) @(posedge clk_i);
  endtask
  // straps change at the next clock edge, with the supply left as it is
  task automatic straps(input logic a, input logic b);
    @(posedge clk_i) strap_a_o <= a;
    strap_b_o <= b;
  endtask
endmodule
`default_nettype wire
